// ---- pkg/tcc_params.svh ----
// Offsets, field positions, reset values and masks of the timer channel block.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// ==========================================================================
// Register byte offsets (channel 1 at the base, channel 2 one word above)
// ==========================================================================
`define OFF_START      8'h00
`define OFF_IOCTL      8'h04
`define OFF_IER        8'h0c
`define OFF_STAT       8'h14
`define OFF_CNT        8'h1c
`define OFF_GRA        8'h24
`define OFF_GRB        8'h2c
`define CH_STRIDE      8'h04

// ==========================================================================
// I/O control field A
// ==========================================================================
`define A_MODE_BIT     3
`define A_INIT_BIT     2
`define A_BOTH_BIT     1
`define A_FALL_BIT     0

// ==========================================================================
// Interrupt enable and status layout
// ==========================================================================
`define IRQ_OVF_BIT    4
`define IRQ_B_BIT      1
`define IRQ_A_BIT      0
`define IER_WMASK      8'hb3
`define IER_ONES       8'h40
`define IER_RST        8'h00
`define STAT_ONES      8'hc0
`define IOCTL_RST      8'h00

// ==========================================================================
// Counter and general register values
// ==========================================================================
`define CNT_RST        16'h0000
`define CNT_MAX        16'hffff
`define CNT_ONE        16'h0001
`define GR_RST         16'hffff

`endif

// ---- pkg/tcc_pkg.sv ----
// Types shared by the timer channel control block.
package tcc_pkg;

   // Action taken on the channel pin at a compare match.
   typedef enum logic [1:0] {
      cmp_off,
      cmp_low,
      cmp_high,
      cmp_toggle
   } cmp_act_type;

endpackage

// ---- rtl/timer_compare_capture_a_ctrl.sv ----
// Two-channel 16-bit compare/capture timer control with an AHB-Lite slave.
// What this block does
// - Top bit 0 gives compare; bit 2 sets initial level; 00 disabled, 01 drives low.
// - Compare mode with low bits 10 drives the A pin high on match.
// - Compare mode with low bits 11 toggles the A pin on each match.
// - Top bit 1 gives capture; low bits 00 capture the counter on rising edge.
// - Capture mode with low bits 01 captures the counter on a falling edge.
// - Capture mode with bit 1 set captures on both edges, bit 0 ignored.
// - Channel 2 capture ignores bit 2 of the A field.
// - Enable bit 4 gates the overflow request from the overflow flag.
// - Enable bit 1 gates the B request from the B flag.
// - Enable bit 0 gates the A request from the A flag.
// - Enable bit 6 always reads 1 and ignores writes.
// - Enable bits 3 and 2 always read 0 and ignore writes.
// - Each channel has its own enable register, cleared at reset; bit 7 is RW.
// - The initial pin level is applied only while the counter is stopped.
// - A flag sets on compare match or on capture into register A.
// - Overflow flag sets when the counter wraps from maximum to zero.
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tcc_params.svh"

module timer_compare_capture_a_ctrl #(
   parameter int CHANNELS = 2                  // Number of timer channels.
)(
   input  wire logic        clk,               // Peripheral clock, 20 MHz.
   input  wire logic        nrst,              // Asynchronous reset, active low.
   input  wire logic        hsel,              // AHB-Lite slave select.
   input  wire logic [31:0] haddr,             // AHB-Lite byte address.
   input  wire logic [1:0]  htrans,            // AHB-Lite transfer type.
   input  wire logic        hwrite,            // AHB-Lite write when high.
   input  wire logic [2:0]  hsize,             // AHB-Lite size, word only.
   input  wire logic [31:0] hwdata,            // AHB-Lite write data.
   input  wire logic        hready,            // AHB-Lite bus ready.
   output wire logic [31:0] hrdata,            // AHB-Lite read data.
   output wire logic        hreadyout,         // AHB-Lite slave ready.
   output wire logic        hresp,             // AHB-Lite response, OKAY.
   input  wire logic        ch1_a_pin_in,      // Channel 1 A pin level.
   input  wire logic        ch2_a_pin_in,      // Channel 2 A pin level.
   output wire logic        ch1_a_pin_out,     // Channel 1 A pin drive.
   output wire logic        ch1_a_pin_oe,      // Channel 1 A pin enable.
   output wire logic        ch2_a_pin_out,     // Channel 2 A pin drive.
   output wire logic        ch2_a_pin_oe,      // Channel 2 A pin enable.
   output wire logic [1:0]  overflow_irq_req,  // Overflow request per channel.
   output wire logic [1:0]  event_a_irq_req,   // A request per channel.
   output wire logic [1:0]  event_b_irq_req,   // B request per channel.
   output wire logic        irq                // Any unmasked flag set.
);

   // =======================================================================
   // Bus slave state
   // =======================================================================
   logic [7:0]  addr_q;                        // Latched low address byte.
   logic        hi_ok_q, wr_pend_q, rd_pend_q; // Address check, phase flags.
   logic        hreadyout_q;                   // Registered slave ready.
   logic [31:0] hrdata_q, rd_val;              // Read data and its source.
   logic        wr_en;                         // Write commits this edge.
   logic [CHANNELS-1:0] run_q;                 // Counter run bits.
   logic [CHANNELS-1:0] pin_in;                // Raw channel pins.
   logic [CHANNELS-1:0] pin_out_w, pin_oe_w;   // Pin drive and enable.
   logic [CHANNELS-1:0] pend_w;                // Unmasked flag per channel.
   logic [31:0]         ch_rd [CHANNELS];      // Read value per channel.
   logic        irq_q;                         // Registered interrupt line.

   assign pin_in = {ch2_a_pin_in, ch1_a_pin_in};
   assign wr_en  = wr_pend_q & hi_ok_q;

   // Address phase capture; writes take no wait, reads take one wait state
   // so that a read placed right after a write sees the written value.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         addr_q      <= 8'h00;
         hi_ok_q     <= 1'b0;
         wr_pend_q   <= 1'b0;
         rd_pend_q   <= 1'b0;
         hreadyout_q <= 1'b1;
         hrdata_q    <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= 1'b0;
         if (rd_pend_q)
         begin
            hrdata_q    <= rd_val;
            hreadyout_q <= 1'b1;
            rd_pend_q   <= 1'b0;
         end
         else if (hsel && hready && htrans[1])
         begin
            addr_q  <= haddr[7:0];
            hi_ok_q <= ~|haddr[31:8];
            if (hwrite)
               wr_pend_q <= 1'b1;
            else
            begin
               rd_pend_q   <= 1'b1;
               hreadyout_q <= 1'b0;
            end
         end
      end
   end

   // Read multiplexer; unmapped addresses read as zero.
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (hi_ok_q && addr_q == `OFF_START)
         rd_val = {30'h0, run_q};
      else if (hi_ok_q)
         rd_val = ch_rd[0] | ch_rd[1];
   end

   // Counter run bits, one per channel.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         run_q <= 2'h0;
      else if (wr_en && addr_q == `OFF_START)
         run_q <= hwdata[1:0];
   end

   // Level interrupt, high while any unmasked status flag is set.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq_q <= 1'b0;
      else
         irq_q <= |pend_w;
   end

   // =======================================================================
   // Per-channel timer logic
   // =======================================================================
   for (genvar g = 0; g < CHANNELS; g++)
   begin : g_ch
      localparam logic [7:0] OFS = 8'(g * 4);
      logic [7:0]  ioctl_q, ier_q;             // I/O control and enables.
      logic [15:0] cnt_q, gra_q, grb_q;        // Counter and general regs.
      logic        ovf_q, fa_q, fb_q;          // Overflow, A and B flags.
      logic        s1_q, s2_q, prev_q;         // Synchroniser, edge history.
      logic        pin_q, oe_q;                // Pin level and enable.
      logic        ovf_req_q, a_req_q, b_req_q; // Registered requests.
      logic        wr_io, wr_ier, wr_st, wr_cnt, wr_gra, wr_grb;
      logic        cap_mode, cap_ok, rise, fall, cap_ev;
      logic        match_a, match_b, ovf_ev, ev_a;
      tcc_pkg::cmp_act_type act;

      // Register write strobes for this channel.
      assign wr_io  = wr_en && addr_q == `OFF_IOCTL + OFS;
      assign wr_ier = wr_en && addr_q == `OFF_IER + OFS;
      assign wr_st  = wr_en && addr_q == `OFF_STAT + OFS;
      assign wr_cnt = wr_en && addr_q == `OFF_CNT + OFS;
      assign wr_gra = wr_en && addr_q == `OFF_GRA + OFS;
      assign wr_grb = wr_en && addr_q == `OFF_GRB + OFS;

      // Mode decode; channel 1 refuses the prohibited 11xx codes.
      assign cap_mode = ioctl_q[`A_MODE_BIT];
      assign cap_ok   = cap_mode &&
                        !(g == 0 && ioctl_q[`A_INIT_BIT]);
      assign act      = tcc_pkg::cmp_act_type'(ioctl_q[1:0]);
      assign rise     = s2_q & ~prev_q;
      assign fall     = ~s2_q & prev_q;
      assign cap_ev   = cap_ok && (ioctl_q[`A_BOTH_BIT] ? (rise | fall)
                        : ioctl_q[`A_FALL_BIT] ? fall
                        : rise);
      assign match_a  = run_q[g] && cnt_q == gra_q;
      assign match_b  = run_q[g] && cnt_q == grb_q;
      assign ovf_ev   = run_q[g] && cnt_q == `CNT_MAX;
      assign ev_a     = cap_ok ? cap_ev : (!cap_mode && match_a);

      // Two-stage pin synchroniser followed by the edge history flop.
      always_ff @(posedge clk or negedge nrst)
      begin
         if (!nrst)
         begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            prev_q <= 1'b0;
         end
         else
         begin
            s1_q   <= pin_in[g];
            s2_q   <= s1_q;
            prev_q <= s2_q;
         end
      end

      // Control registers; enable register keeps only its writable bits.
      always_ff @(posedge clk or negedge nrst)
      begin
         if (!nrst)
         begin
            ioctl_q <= `IOCTL_RST;
            ier_q   <= `IER_RST;
         end
         else
         begin
            if (wr_io)
               ioctl_q <= hwdata[7:0];
            if (wr_ier)
               ier_q <= hwdata[7:0] & `IER_WMASK;
         end
      end

      // Counter runs one step per clock while started; wraps to zero.
      always_ff @(posedge clk or negedge nrst)
      begin
         if (!nrst)
            cnt_q <= `CNT_RST;
         else if (wr_cnt)
            cnt_q <= hwdata[15:0];
         else if (run_q[g])
            cnt_q <= cnt_q + `CNT_ONE;
      end

      // General registers; a capture wins over a software write.
      always_ff @(posedge clk or negedge nrst)
      begin
         if (!nrst)
         begin
            gra_q <= `GR_RST;
            grb_q <= `GR_RST;
         end
         else
         begin
            if (cap_ev)
               gra_q <= cnt_q;
            else if (wr_gra)
               gra_q <= hwdata[15:0];
            if (wr_grb)
               grb_q <= hwdata[15:0];
         end
      end

      // Sticky flags cleared by writing one; a new event beats the clear.
      always_ff @(posedge clk or negedge nrst)
      begin
         if (!nrst)
         begin
            ovf_q <= 1'b0;
            fa_q  <= 1'b0;
            fb_q  <= 1'b0;
         end
         else
         begin
            ovf_q <= ovf_ev |
                     (ovf_q & ~(wr_st & hwdata[`IRQ_OVF_BIT]));
            fa_q  <= ev_a | (fa_q & ~(wr_st & hwdata[`IRQ_A_BIT]));
            fb_q  <= match_b | (fb_q & ~(wr_st & hwdata[`IRQ_B_BIT]));
         end
      end

      // Pin level: initial value loads only while stopped, match acts when run.
      always_ff @(posedge clk or negedge nrst)
      begin
         if (!nrst)
         begin
            pin_q <= 1'b0;
            oe_q  <= 1'b0;
         end
         else
         begin
            oe_q <= !cap_mode && act != tcc_pkg::cmp_off;
            if (wr_io && !run_q[g])
               pin_q <= hwdata[`A_INIT_BIT];
            else if (!cap_mode && match_a)
            begin
               case (act)
                  tcc_pkg::cmp_low:    pin_q <= 1'b0;
                  tcc_pkg::cmp_high:   pin_q <= 1'b1;
                  tcc_pkg::cmp_toggle: pin_q <= ~pin_q;
                  default:             pin_q <= pin_q;
               endcase
            end
         end
      end

      // Interrupt requests are flag AND enable, registered.
      always_ff @(posedge clk or negedge nrst)
      begin
         if (!nrst)
         begin
            ovf_req_q <= 1'b0;
            a_req_q   <= 1'b0;
            b_req_q   <= 1'b0;
         end
         else
         begin
            ovf_req_q <= ovf_q & ier_q[`IRQ_OVF_BIT];
            b_req_q   <= fb_q & ier_q[`IRQ_B_BIT];
            a_req_q   <= fa_q & ier_q[`IRQ_A_BIT];
         end
      end

      // Per-channel read value; zero when no register of this channel hits.
      always_comb
      begin
         ch_rd[g] = 32'h0000_0000;
         if (addr_q == `OFF_IOCTL + OFS)
            ch_rd[g] = {24'h00_0000, ioctl_q};
         else if (addr_q == `OFF_IER + OFS)
            ch_rd[g] = {24'h00_0000, ier_q | `IER_ONES};
         else if (addr_q == `OFF_STAT + OFS)
            ch_rd[g] = {24'h00_0000, `STAT_ONES |
                        {3'h0, ovf_q, 2'h0, fb_q, fa_q}};
         else if (addr_q == `OFF_CNT + OFS)
            ch_rd[g] = {16'h0000, cnt_q};
         else if (addr_q == `OFF_GRA + OFS)
            ch_rd[g] = {16'h0000, gra_q};
         else if (addr_q == `OFF_GRB + OFS)
            ch_rd[g] = {16'h0000, grb_q};
      end

      assign pin_out_w[g] = pin_q;
      assign pin_oe_w[g]  = oe_q;
      assign pend_w[g]    = (ovf_q & ier_q[`IRQ_OVF_BIT]) |
                            (fb_q & ier_q[`IRQ_B_BIT]) |
                            (fa_q & ier_q[`IRQ_A_BIT]);
      assign overflow_irq_req[g] = ovf_req_q;
      assign event_a_irq_req[g]  = a_req_q;
      assign event_b_irq_req[g]  = b_req_q;
   end

   // =======================================================================
   // Output connections, all from flip-flops except hresp, which is tied low
   // =======================================================================
   assign hrdata        = hrdata_q;
   assign hreadyout     = hreadyout_q;
   assign hresp         = 1'b0;
   assign irq           = irq_q;
   assign ch1_a_pin_out = pin_out_w[0];
   assign ch1_a_pin_oe  = pin_oe_w[0];
   assign ch2_a_pin_out = pin_out_w[1];
   assign ch2_a_pin_oe  = pin_oe_w[1];

endmodule

// ---- dv/tcc_props.sv ----
// Checker of bus timing, readback layout, pin enables and interrupt line.
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_props #(
   parameter int CHANNELS = 2 // Number of timer channels.
)(
   input wire logic        clk, // Clock.
   input wire logic        nrst, // Reset, active low.
   input wire logic        hsel, // Select.
   input wire logic [31:0] haddr, // Address.
   input wire logic [1:0]  htrans, // Transfer type.
   input wire logic        hwrite, // Write.
   input wire logic [2:0]  hsize, // Size.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic        hready, // Bus ready.
   input wire logic [31:0] hrdata, // Read data.
   input wire logic        hreadyout, // Slave ready.
   input wire logic        hresp, // Response.
   input wire logic        ch1_a_pin_in, // Pin 1 level.
   input wire logic        ch2_a_pin_in, // Pin 2 level.
   input wire logic        ch1_a_pin_out, // Pin 1 drive.
   input wire logic        ch1_a_pin_oe, // Pin 1 enable.
   input wire logic        ch2_a_pin_out, // Pin 2 drive.
   input wire logic        ch2_a_pin_oe, // Pin 2 enable.
   input wire logic [1:0]  overflow_irq_req, // Overflow requests.
   input wire logic [1:0]  event_a_irq_req, // A requests.
   input wire logic [1:0]  event_b_irq_req, // B requests.
   input wire logic        irq // Interrupt line.
);
   // ========================================
   // Helper logic and sequences
   // ========================================
   logic dph_q;

   // Marks the data phase of a write, when the write commits.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         dph_q <= 1'b0;
      else
         dph_q <= hsel && hready && htrans[1] && hwrite;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_rd(logic [7:0] a);
      hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 24'h0 &&
      (haddr[7:0] == a || haddr[7:0] == a + `CH_STRIDE);
   endsequence
   sequence s_wr(logic [7:0] a);
      hsel && hready && htrans[1] && hwrite && haddr == {24'h0, a};
   endsequence
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   // ========================================
   // Assertions
   // ========================================
   AST_HRESP_OKAY: assert property (hresp == 1'b0)
      else $error("response is not OKAY");
   AST_RD_WAIT: assert property (hsel && hready && htrans[1] && !hwrite
      |=> s_wait) else $error("read wait state wrong");
   AST_WR_NOWAIT: assert property (hsel && hready && htrans[1] && hwrite
      |=> hreadyout) else $error("write was stalled");
   AST_IER_RSVD: assert property (s_rd(`OFF_IER) |=> s_wait ##0
      (hrdata[31:8] == 24'h0 && hrdata[6] && hrdata[3:2] == 2'b00))
      else $error("enable readback layout wrong");
   AST_STAT_RSVD: assert property (s_rd(`OFF_STAT) |=> s_wait ##0
      (hrdata[31:8] == 24'h0 && hrdata[7:5] == 3'b110 && hrdata[3:2] == 2'b00))
      else $error("status readback layout wrong");
   AST_IRQ_OR: assert property (irq == (|overflow_irq_req ||
      |event_a_irq_req || |event_b_irq_req)) else $error("irq not OR");
   AST_IRQ_FALL: assert property ($fell(irq) |->
      $past(dph_q, 2) || $past(dph_q, 3)) else $error("irq fell unasked");
   AST_OE_CAP1: assert property (s_wr(`OFF_IOCTL) ##1 hwdata[3]
      |-> ##[1:2] !ch1_a_pin_oe) else $error("pin 1 driven in capture");
   AST_OE_ON1: assert property (s_wr(`OFF_IOCTL)
      ##1 (!hwdata[3] && hwdata[1:0] != 2'b00) |-> ##[1:2] ch1_a_pin_oe)
      else $error("pin 1 not driven in compare");
   AST_OE_OFF2: assert property (s_wr(8'h08)
      ##1 (hwdata[3] || hwdata[1:0] == 2'b00) |-> ##[1:2] !ch2_a_pin_oe)
      else $error("pin 2 driven while disabled");
endmodule

bind timer_compare_capture_a_ctrl tcc_props #(.CHANNELS(CHANNELS)) i_props (
   .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .ch1_a_pin_in(ch1_a_pin_in), .ch2_a_pin_in(ch2_a_pin_in),
   .ch1_a_pin_out(ch1_a_pin_out), .ch1_a_pin_oe(ch1_a_pin_oe),
   .ch2_a_pin_out(ch2_a_pin_out), .ch2_a_pin_oe(ch2_a_pin_oe),
   .overflow_irq_req(overflow_irq_req), .event_a_irq_req(event_a_irq_req),
   .event_b_irq_req(event_b_irq_req), .irq(irq));

// ---- dv/tcc_pin_model.sv ----
// Model of the two channel A pins, shared by the block and an outside source.
`timescale 1ns/1ps

module tcc_pin_model (
   input  wire logic drv1, // Outside level on pin 1.
   input  wire logic drv2, // Outside level on pin 2.
   input  wire logic out1, // Block drive on pin 1.
   input  wire logic oe1, // Block enable on pin 1.
   input  wire logic out2, // Block drive on pin 2.
   input  wire logic oe2, // Block enable on pin 2.
   output wire logic pin1, // Resolved pin 1.
   output wire logic pin2 // Resolved pin 2.
);
   // The block owns a pin while it drives it; the outside source otherwise.
   assign pin1 = oe1 ? out1 : drv1;
   assign pin2 = oe2 ? out2 : drv2;
endmodule

// ---- dv/test_timer_compare_capture_a_ctrl.sv ----
// Self-checking bench of the two-channel compare/capture timer block.
`timescale 1ns/1ps
`include "tcc_params.svh"

module test_timer_compare_capture_a_ctrl;
   // ========================================
   // Signals and model state
   // ========================================
   logic        clk, nrst, hsel, hwrite, drv1, drv2;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, rv;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, p1o, p1e, p2o, p2e, pin1, pin2, irq;
   wire  [1:0]  ovr, ear, ebr;
   int          failures, cmp_count;
   int          ier_m [2];

   // Clock of 50 ns.
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   timer_compare_capture_a_ctrl i_dut (
      .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ch1_a_pin_in(pin1), .ch2_a_pin_in(pin2),
      .ch1_a_pin_out(p1o), .ch1_a_pin_oe(p1e),
      .ch2_a_pin_out(p2o), .ch2_a_pin_oe(p2e),
      .overflow_irq_req(ovr), .event_a_irq_req(ear),
      .event_b_irq_req(ebr), .irq(irq));

   tcc_pin_model i_pins (
      .drv1(drv1), .drv2(drv2), .out1(p1o), .oe1(p1e), .out2(p2o),
      .oe2(p2e), .pin1(pin1), .pin2(pin2));

   // ========================================
   // Tasks
   // ========================================
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One single transfer; the answer is awaited, never assumed.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a};
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rv = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      bus(1'b0, a, 32'h0);
      chk(n, e, rv);
   endtask

   task automatic set_drv(input int c, input logic v);
      if (c == 0)
         drv1 <= v;
      else
         drv2 <= v;
   endtask

   task automatic wait_req(input int c, input bit ov);
      int n;
      n = 0;
      while ((ov ? ovr[c] : ear[c]) !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
   endtask

   // Compare code k on channel c: enable, initial level and match action.
   task automatic cmp_code(input int c, input logic [3:0] k);
      logic [7:0] o;
      logic       pe;
      o = 8'(c * 4);
      wr(`OFF_START, 32'h0);
      wr(`OFF_IOCTL + o, {28'h0, k});
      wr(`OFF_CNT + o, 32'h0);
      wr(`OFF_GRA + o, 32'(8 + $urandom % 24));
      wr(`OFF_STAT + o, 32'h13);
      wr(`OFF_IER + o, 32'h01);
      @(posedge clk);
      chk("oe", 32'(k[1:0] != 2'b00), 32'(c ? p2e : p1e));
      if (k[1:0] != 2'b00)
         chk("init", 32'(k[2]), 32'(c ? p2o : p1o));
      wr(`OFF_START, 32'(1 << c));
      wait_req(c, 1'b0);
      chk("irq a", 32'h1, 32'(ear[c]));
      pe = (k[1:0] == 2'b01) ? 1'b0 : (k[1:0] == 2'b10) ? 1'b1 : ~k[2];
      if (k[1:0] != 2'b00)
      begin
         chk("match pin", 32'(pe), 32'(c ? p2o : p1o));
         wr(`OFF_IOCTL + o, {28'h0, k ^ 4'h4});
         @(posedge clk);
         chk("run pin", 32'(pe), 32'(c ? p2o : p1o));
      end
      wr(`OFF_START, 32'h0);
      wr(`OFF_STAT + o, 32'h01);
      repeat (2) @(posedge clk);
      chk("irq clr", 32'h0, 32'(irq));
   endtask

   // Capture code k on channel c: a rising then a falling pin edge.
   task automatic cap_code(input int c, input logic [3:0] k);
      logic [7:0] o;
      o = 8'(c * 4);
      wr(`OFF_START, 32'h0);
      set_drv(c, 1'b0);
      wr(`OFF_IOCTL + o, {28'h0, k});
      repeat (6) @(posedge clk);
      wr(`OFF_GRA + o, 32'hffff);
      wr(`OFF_CNT + o, 32'h0);
      wr(`OFF_STAT + o, 32'h13);
      wr(`OFF_START, 32'(1 << c));
      set_drv(c, 1'b1);
      repeat (8) @(posedge clk);
      rd(`OFF_STAT + o, 32'hc0 | 32'(k[1] || !k[0]), "rise");
      bus(1'b0, `OFF_GRA + o, 32'h0);
      chk("cap val", 32'(k[1] || !k[0]), 32'(rv !== 32'hffff));
      wr(`OFF_STAT + o, 32'h01);
      set_drv(c, 1'b0);
      repeat (8) @(posedge clk);
      rd(`OFF_STAT + o, 32'hc0 | 32'(k[1] | k[0]), "fall");
      wr(`OFF_STAT + o, 32'h01);
   endtask

   // Counter wrap on channel c with overflow and B requests, then masking.
   task automatic ovf_case(input int c);
      logic [7:0] o;
      o = 8'(c * 4);
      wr(`OFF_START, 32'h0);
      wr(`OFF_IOCTL + o, 32'h0);
      wr(`OFF_GRA + o, 32'h8000);
      wr(`OFF_IER + o, 32'h12);
      wr(`OFF_CNT + o, 32'hfff0);
      wr(`OFF_STAT + o, 32'h13);
      wr(`OFF_START, 32'(1 << c));
      wait_req(c, 1'b1);
      chk("irq ovf", 32'h1, 32'(ovr[c]));
      chk("irq b", 32'h1, 32'(ebr[c]));
      wr(`OFF_START, 32'h0);
      rd(`OFF_STAT + o, 32'hd2, "ovf stat");
      wr(`OFF_IER + o, 32'h00);
      repeat (2) @(posedge clk);
      chk("masked", 32'h0, 32'({ovr[c], ebr[c], irq}));
      wr(`OFF_STAT + o, 32'h12);
      rd(`OFF_STAT + o, 32'hc0, "stat clr");
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ========================================
   // Main sequence
   // ========================================
   initial
   begin
      logic [7:0] d;
      failures  = 0;
      cmp_count = 0;
      nrst      = 1'b0;
      hsel      = 1'b0;
      htrans    = 2'b00;
      hwrite    = 1'b0;
      hsize     = 3'b010;
      haddr     = 32'h0;
      hwdata    = 32'h0;
      drv1      = 1'b0;
      drv2      = 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      void'($urandom(30));
      for (int c = 0; c < 2; c++)
      begin
         rd(`OFF_IER + 8'(c * 4), 32'h40, "ier rst");
         rd(`OFF_STAT + 8'(c * 4), 32'hc0, "stat rst");
         rd(`OFF_IOCTL + 8'(c * 4), 32'h0, "ioctl rst");
         rd(`OFF_GRA + 8'(c * 4), 32'hffff, "gra rst");
      end
      rd(8'h80, 32'h0, "unmapped");
      for (int c = 0; c < 2; c++)
      begin
         d = 8'($urandom) & 8'hdf;
         ier_m[c] = int'((d & 8'hb3) | 8'h40);
         wr(`OFF_IER + 8'(c * 4), {24'h0, d});
      end
      for (int c = 0; c < 2; c++)
         rd(`OFF_IER + 8'(c * 4), 32'(ier_m[c]), "ier rw");
      for (int c = 0; c < 2; c++)
         for (int k = 0; k < 8; k++)
            cmp_code(c, 4'(k));
      for (int k = 8; k < 16; k++)
      begin
         if (k < 12)
            cap_code(0, 4'(k));
         cap_code(1, 4'(k));
      end
      for (int c = 0; c < 2; c++)
         ovf_case(c);
      print_verdict;
   end

   // Cuts a hang short.
   initial
   begin
      repeat (50000) @(posedge clk);
      failures++;
      print_verdict;
   end
endmodule
